/* File: rtl/core_regs_pkg.sv */
/*
  Constants shared by the core special-register bank: offsets, field positions,
  reset values, bus offsets and widths.
  Assumes a single 250 MHz clock domain and a 32-bit AXI4-Lite register bus.
*/
package core_regs_pkg;

  // ****************************************************************
  // Core register offsets in the data space.
  // ****************************************************************
  localparam logic [5:0] ADDR_INDIRECT = 6'h00; // Virtual indirect pointer port.
  localparam logic [5:0] ADDR_TIMER = 6'h01; // Timer count, not held here.
  localparam logic [5:0] ADDR_PC_LOW = 6'h02; // Program counter low byte.
  localparam logic [5:0] ADDR_STATUS = 6'h03; // Core status.
  localparam logic [5:0] ADDR_RAM_SEL = 6'h04; // RAM select.
  localparam logic [5:0] ADDR_PORT5 = 6'h05; // Port five data.
  localparam logic [5:0] ADDR_PORT6 = 6'h06; // Port six data.
  localparam logic [5:0] ADDR_PORT7 = 6'h07; // Port seven data.
  localparam logic [5:0] ADDR_GEN_LO = 6'h10; // First shared general register.
  localparam logic [5:0] ADDR_BANK_LO = 6'h20; // First banked general register.

  // ****************************************************************
  // Status and RAM select field positions.
  // ****************************************************************
  localparam int ST_WAKE = 7; // Wake cause.
  localparam int ST_SEG = 6; // Control segment select.
  localparam int ST_PAGE = 5; // Program page select.
  localparam int ST_TO = 4; // Time-out flag.
  localparam int ST_PD = 3; // Power-down flag.
  localparam int ST_Z = 2; // Zero flag.
  localparam int ST_HC = 1; // Half-carry flag.
  localparam int ST_C = 0; // Carry flag.
  localparam int RS_TOP = 7; // Always-zero bit.
  localparam int RS_BANK = 6; // Bank select bit.
  localparam logic [7:0] RS_WMASK = 8'h7f; // Writable bits of RAM select.
  localparam logic [7:0] P7_MASK = 8'h01; // Implemented bits of port seven.

  // ****************************************************************
  // Reset values and widths.
  // ****************************************************************
  localparam logic [7:0] STATUS_POR = 8'h18; // Time-out and power-down set.
  localparam logic [7:0] BYTE_ZERO = 8'h00; // Cleared byte.
  localparam int PC_W = 11; // Program counter and stack width.
  localparam logic [PC_W-1:0] PC_RESET = 11'h000; // Program counter reset value.
  localparam int STACK_DEPTH = 8; // Return stack depth, chosen value.
  localparam logic [2:0] SP_ONE = 3'h1; // Stack pointer step.
  localparam logic [PC_W-1:0] PC_ONE = 11'h001; // Program counter step.

  // ****************************************************************
  // AXI4-Lite map of the bus-visible registers.
  // ****************************************************************
  localparam logic [7:0] AXI_STATUS = 8'h0c; // Core status, word at 0x03 times four.
  localparam logic [7:0] AXI_RAM_SEL = 8'h10; // RAM select.
  localparam logic [7:0] AXI_PORT5 = 8'h14; // Port five.
  localparam logic [7:0] AXI_PORT6 = 8'h18; // Port six.
  localparam logic [7:0] AXI_PORT7 = 8'h1c; // Port seven.
  localparam logic [7:0] AXI_PC = 8'h20; // Program counter, read only.
  localparam logic [7:0] AXI_IRQ_STAT = 8'h24; // Sticky event status, read clears.
  localparam logic [7:0] AXI_IRQ_MASK = 8'h28; // Event mask.
  localparam logic [1:0] RESP_OKAY = 2'b00; // Bus OKAY answer.
  localparam logic [1:0] RESP_SLVERR = 2'b10; // Bus error answer.
  localparam int EV_W = 4; // Event bits: wake, watchdog, sleep, write to PC.

endpackage

/* File: rtl/reset_sync.sv */
/*
  Reset release synchroniser: asserts asynchronously, releases after two edges.
  Assumes the raw reset is active low.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Raw reset, active low.
  output logic rst_sync_n // Released reset, active low.
);

  logic stage_n; // First stage, read only by the second.

  // Two flops so release never lands near a clock edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      stage_n <= 1'b1;
      rst_sync_n <= stage_n;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/return_stack.sv */
/*
  Hardware return stack holding full 11-bit return addresses.
  Assumes the sequencer never pushes and pops in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module return_stack (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronised reset, active low.
  input wire logic push, // Push a return address.
  input wire logic pop, // Pop the top address.
  input wire logic [core_regs_pkg::PC_W-1:0] push_addr, // Address pushed.
  output logic [core_regs_pkg::PC_W-1:0] top_addr // Top address, combinational.
);

  logic [core_regs_pkg::PC_W-1:0] mem [core_regs_pkg::STACK_DEPTH]; // Stack words.
  logic [2:0] sp; // Points at the next free slot; wraps when full.

  // Top of stack is the slot below the pointer.
  assign top_addr = mem[sp - core_regs_pkg::SP_ONE];

  // Pointer moves on push or pop, overflow wraps silently.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sp <= 3'h0;
    end else if (push) begin
      sp <= sp + core_regs_pkg::SP_ONE;
    end else if (pop) begin
      sp <= sp - core_regs_pkg::SP_ONE;
    end
  end

  // Storage needs no reset.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[sp] <= push_addr;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/core_status_bank_select.sv */
/*
  Core special-register bank: status, RAM select, port data, program counter
  with page select, indirect address resolution and an AXI4-Lite view.
  Assumes the instruction sequencer and arithmetic unit share clk_sys and
  present one access and one control event per cycle.
*/
//
// Contract
// - Wake bit set on pin/comparator/converter wake
// - Segment bit picks control register group
// - Page bit loads PC bit ten
// - Returns restore full address, page untouched
// - Page zero low half, one high
// - Time-out set by reset/sleep/clear, watchdog clears
// - Power-down set by reset/clear, sleep clears
// - Zero flag follows arithmetic zero result
// - Half-carry bit one, carry bit zero
// - RAM select top bit always zero
// - RAM select bit six picks bank
// - RAM select low six bits address indirectly
// - Port five and six read/write registers
// - Port seven only lowest bit implemented
// - Address zero redirects through RAM select
// - PC and stack eleven bits, reset zero
`timescale 1ns/1ps
`default_nettype none
module core_status_bank_select (
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic rst_n, // Reset, active low, asynchronous.
  // Core data access port.
  input wire logic core_we, // Write strobe from the sequencer.
  input wire logic core_re, // Read strobe from the sequencer.
  input wire logic [5:0] core_addr, // Direct register address.
  input wire logic [7:0] core_wdata, // Write data.
  output logic [7:0] core_rdata, // Read data, registered.
  output logic [5:0] eff_addr, // Resolved address, registered.
  output logic eff_bank, // Resolved bank, registered.
  // Arithmetic unit flag update.
  input wire logic alu_flag_we, // Flags valid with the result.
  input wire logic alu_zero, // Result is zero.
  input wire logic alu_half_carry, // Half carry out.
  input wire logic alu_carry, // Carry out.
  // Sequencer control events.
  input wire logic ev_sleep, // Sleep instruction.
  input wire logic ev_wdt_clear, // Watchdog-clear instruction.
  input wire logic ev_wdt_timeout, // Watchdog time-out.
  input wire logic ev_wake_pin, // Wake by pin, comparator or converter.
  input wire logic ev_wake_other, // Wake or reset of another kind.
  input wire logic pc_jump, // Jump or call load of low ten bits.
  input wire logic pc_call, // Call pushes the return address.
  input wire logic pc_ret, // Any return instruction.
  input wire logic pc_step, // Ordinary increment.
  input wire logic [9:0] pc_target, // Jump target low ten bits.
  output logic [core_regs_pkg::PC_W-1:0] pc, // Program counter.
  output logic ctrl_segment, // Control segment select.
  // Port data.
  input wire logic [7:0] port5_in, // Port five pin levels.
  input wire logic [7:0] port6_in, // Port six pin levels.
  input wire logic port7_in, // Port seven pin level.
  output logic [7:0] port5_out, // Port five latch.
  output logic [7:0] port6_out, // Port six latch.
  output logic port7_out, // Port seven latch.
  output logic irq, // Level interrupt.
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // Reset and helpers.
  // ****************************************************************
  logic rst_sync_n; // Synchronised reset.
  logic [core_regs_pkg::PC_W-1:0] stack_top; // Top of return stack.
  logic [7:0] status; // Core status register.
  logic [7:0] ram_select; // RAM select register.
  logic [7:0] gen_mem [64]; // Shared and bank zero registers 10-3F.
  logic [7:0] bank1_mem [32]; // Bank one registers 20-3F.
  localparam int EV_STAT_HI = core_regs_pkg::EV_W - 1; // Top event bit.
  logic [EV_STAT_HI:0] ev_stat; // Sticky events.
  logic [EV_STAT_HI:0] ev_mask; // Event mask.

  reset_sync u_rst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  return_stack u_stack (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_n),
    .push(pc_call),
    .pop(pc_ret),
    .push_addr(pc + core_regs_pkg::PC_ONE),
    .top_addr(stack_top)
  );

  // Resolves an address through the indirect port.
  function automatic logic [5:0] resolve(input logic [5:0] a, input logic [7:0] rs);
    resolve = (a == core_regs_pkg::ADDR_INDIRECT) ? rs[5:0] : a;
  endfunction

  // Tells whether an address sits in the banked half.
  function automatic logic in_bank(input logic [5:0] a);
    in_bank = (a >= core_regs_pkg::ADDR_BANK_LO);
  endfunction

  logic [5:0] next_eff; // Resolved address of this access.
  logic next_bank; // Bank one chosen for this access.
  logic pc_written; // Store into the low counter byte.
  logic [7:0] bus_wbyte; // Bus write byte.
  logic bus_wr; // Bus write accepted this cycle.
  logic [7:0] bus_waddr; // Latched bus write address.
  assign next_eff = resolve(core_addr, ram_select);
  assign next_bank = ram_select[core_regs_pkg::RS_BANK] && in_bank(next_eff);
  assign pc_written = core_we && (next_eff == core_regs_pkg::ADDR_PC_LOW);

  // ****************************************************************
  // Program counter.
  // ****************************************************************
  // Jumps and stores pull in the page bit; returns take the full stacked address.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pc <= core_regs_pkg::PC_RESET;
    end else if (pc_ret) begin
      pc <= stack_top;
    end else if (pc_jump) begin
      pc <= {status[core_regs_pkg::ST_PAGE], pc_target};
    end else if (pc_written) begin
      pc <= {status[core_regs_pkg::ST_PAGE], pc[9:8], core_wdata};
    end else if (pc_step) begin
      pc <= pc + core_regs_pkg::PC_ONE;
    end
  end

  // ****************************************************************
  // Status register.
  // ****************************************************************
  // Hardware events outrank software stores; the page bit is never touched by returns.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status <= core_regs_pkg::STATUS_POR;
    end else begin
      if (core_we && next_eff == core_regs_pkg::ADDR_STATUS) begin
        // Software writes segment, page and arithmetic flags only.
        status[core_regs_pkg::ST_SEG] <= core_wdata[core_regs_pkg::ST_SEG];
        status[core_regs_pkg::ST_PAGE] <= core_wdata[core_regs_pkg::ST_PAGE];
        status[2:0] <= core_wdata[2:0];
      end else if (bus_wr && bus_waddr == core_regs_pkg::AXI_STATUS) begin
        status[core_regs_pkg::ST_SEG] <= bus_wbyte[core_regs_pkg::ST_SEG];
        status[core_regs_pkg::ST_PAGE] <= bus_wbyte[core_regs_pkg::ST_PAGE];
        status[2:0] <= bus_wbyte[2:0];
      end
      if (alu_flag_we) begin
        status[core_regs_pkg::ST_Z] <= alu_zero;
        status[core_regs_pkg::ST_HC] <= alu_half_carry;
        status[core_regs_pkg::ST_C] <= alu_carry;
      end
      if (ev_wake_pin) begin
        status[core_regs_pkg::ST_WAKE] <= 1'b1;
      end else if (ev_wake_other) begin
        status[core_regs_pkg::ST_WAKE] <= 1'b0;
      end
      if (ev_wdt_timeout) begin
        status[core_regs_pkg::ST_TO] <= 1'b0;
      end else if (ev_sleep || ev_wdt_clear) begin
        status[core_regs_pkg::ST_TO] <= 1'b1;
      end
      if (ev_wdt_clear) begin
        status[core_regs_pkg::ST_PD] <= 1'b1;
      end else if (ev_sleep) begin
        status[core_regs_pkg::ST_PD] <= 1'b0;
      end
    end
  end

  // Segment select drives the control register group choice.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_segment <= 1'b0;
    end else begin
      ctrl_segment <= status[core_regs_pkg::ST_SEG];
    end
  end

  // ****************************************************************
  // RAM select and port latches.
  // ****************************************************************
  // Top bit of RAM select is masked on every store.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ram_select <= core_regs_pkg::BYTE_ZERO;
    end else if (core_we && next_eff == core_regs_pkg::ADDR_RAM_SEL) begin
      ram_select <= core_wdata & core_regs_pkg::RS_WMASK;
    end else if (bus_wr && bus_waddr == core_regs_pkg::AXI_RAM_SEL) begin
      ram_select <= bus_wbyte & core_regs_pkg::RS_WMASK;
    end
  end

  // Port data latches written from the core or the bus.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port5_out <= core_regs_pkg::BYTE_ZERO;
      port6_out <= core_regs_pkg::BYTE_ZERO;
      port7_out <= 1'b0;
    end else begin
      if (core_we && next_eff == core_regs_pkg::ADDR_PORT5) begin
        port5_out <= core_wdata;
      end else if (bus_wr && bus_waddr == core_regs_pkg::AXI_PORT5) begin
        port5_out <= bus_wbyte;
      end
      if (core_we && next_eff == core_regs_pkg::ADDR_PORT6) begin
        port6_out <= core_wdata;
      end else if (bus_wr && bus_waddr == core_regs_pkg::AXI_PORT6) begin
        port6_out <= bus_wbyte;
      end
      if (core_we && next_eff == core_regs_pkg::ADDR_PORT7) begin
        port7_out <= core_wdata[0];
      end else if (bus_wr && bus_waddr == core_regs_pkg::AXI_PORT7) begin
        port7_out <= bus_wbyte[0];
      end
    end
  end

  // ****************************************************************
  // General registers and core reads.
  // ****************************************************************
  // Registers 10-1F are shared; 20-3F split by the bank bit.
  always_ff @(posedge clk_sys) begin
    if (core_we && next_eff >= core_regs_pkg::ADDR_GEN_LO) begin
      if (next_bank) begin
        bank1_mem[next_eff[4:0]] <= core_wdata;
      end else begin
        gen_mem[next_eff] <= core_wdata;
      end
    end
  end

  // Read mux, registered; indirect through address zero resolves first.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_rdata <= core_regs_pkg::BYTE_ZERO;
      eff_addr <= 6'h00;
      eff_bank <= 1'b0;
    end else begin
      eff_addr <= next_eff;
      eff_bank <= next_bank;
      if (core_re) begin
        case (next_eff)
          core_regs_pkg::ADDR_PC_LOW: core_rdata <= pc[7:0];
          core_regs_pkg::ADDR_STATUS: core_rdata <= status;
          core_regs_pkg::ADDR_RAM_SEL: core_rdata <= ram_select;
          core_regs_pkg::ADDR_PORT5: core_rdata <= port5_in;
          core_regs_pkg::ADDR_PORT6: core_rdata <= port6_in;
          core_regs_pkg::ADDR_PORT7: core_rdata <= {7'h00, port7_in};
          default: begin
            if (next_eff < core_regs_pkg::ADDR_GEN_LO) begin
              core_rdata <= core_regs_pkg::BYTE_ZERO;
            end else if (next_bank) begin
              core_rdata <= bank1_mem[next_eff[4:0]];
            end else begin
              core_rdata <= gen_mem[next_eff];
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Events and interrupt.
  // ****************************************************************
  logic [EV_STAT_HI:0] ev_now; // Events of this cycle.
  logic stat_read; // Bus read of the event status.
  assign ev_now = {pc_written, ev_sleep, ev_wdt_timeout, ev_wake_pin};

  // Read clears, but an event in the same cycle survives.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ev_stat <= '0;
    end else if (stat_read) begin
      ev_stat <= ev_now;
    end else begin
      ev_stat <= ev_stat | ev_now;
    end
  end

  // Level interrupt while any unmasked bit is set.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((ev_stat | ev_now) & ev_mask);
    end
  end

  // ****************************************************************
  // AXI4-Lite slave.
  // ****************************************************************
  logic aw_held; // Write address taken.
  logic w_held; // Write data taken.
  logic [7:0] wbyte_held; // Write data byte.
  logic [7:0] awaddr_held; // Write address.
  assign bus_wr = aw_held && w_held && !s_axi_bvalid;
  assign bus_waddr = awaddr_held;
  assign bus_wbyte = wbyte_held;
  assign stat_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == core_regs_pkg::AXI_IRQ_STAT;

  // Takes address and data in either order, answers one cycle after both.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_held <= 8'h00;
      wbyte_held <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= core_regs_pkg::RESP_OKAY;
      ev_mask <= '0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_held <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wbyte_held <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (bus_wr) begin
        s_axi_bvalid <= 1'b1;
        case (awaddr_held)
          core_regs_pkg::AXI_STATUS, core_regs_pkg::AXI_RAM_SEL, core_regs_pkg::AXI_PORT5,
          core_regs_pkg::AXI_PORT6, core_regs_pkg::AXI_PORT7, core_regs_pkg::AXI_PC,
          core_regs_pkg::AXI_IRQ_STAT: s_axi_bresp <= core_regs_pkg::RESP_OKAY;
          core_regs_pkg::AXI_IRQ_MASK: begin
            s_axi_bresp <= core_regs_pkg::RESP_OKAY;
            ev_mask <= wbyte_held[EV_STAT_HI:0];
          end
          default: s_axi_bresp <= core_regs_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, answer the cycle after the address.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= core_regs_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= core_regs_pkg::RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          core_regs_pkg::AXI_STATUS: s_axi_rdata <= {24'h000000, status};
          core_regs_pkg::AXI_RAM_SEL: s_axi_rdata <= {24'h000000, ram_select};
          core_regs_pkg::AXI_PORT5: s_axi_rdata <= {24'h000000, port5_in};
          core_regs_pkg::AXI_PORT6: s_axi_rdata <= {24'h000000, port6_in};
          core_regs_pkg::AXI_PORT7: s_axi_rdata <= {31'h00000000, port7_in};
          core_regs_pkg::AXI_PC: s_axi_rdata <= {21'h000000, pc};
          core_regs_pkg::AXI_IRQ_STAT: s_axi_rdata <= {28'h0000000, ev_stat};
          core_regs_pkg::AXI_IRQ_MASK: s_axi_rdata <= {28'h0000000, ev_mask};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= core_regs_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/core_regs_assertions.sv */
/* Port checker for the core register bank.
   Assumes it is bound to each core_status_bank_select instance. */
`timescale 1ns/1ps
`default_nettype none
module core_regs_assertions (
  input wire logic clk_sys, rst_n, core_we, core_re, eff_bank, pc_jump, pc_ret, pc_step, port7_out,
  input wire logic [5:0] core_addr, eff_addr,
  input wire logic [7:0] core_wdata, core_rdata, port5_out,
  input wire logic [9:0] pc_target,
  input wire logic [core_regs_pkg::PC_W-1:0] pc
);
  // ****************************************************************
  // Checks, all in the one clock domain.
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_pc_reset: assert property ($rose(rst_n) |-> pc == 11'h000) else $error("pc not zero at reset");
  chk_jump_low: assert property (pc_jump && !pc_ret |=> pc[9:0] == $past(pc_target))
    else $error("jump target not loaded");
  chk_pc_step: assert property (pc_step && !pc_ret && !pc_jump && !core_we |=> pc == $past(pc) + 11'h001)
    else $error("pc did not step");
  chk_shared_bank: assert property (core_addr inside {[6'h10:6'h1f]} |=> !eff_bank)
    else $error("shared register banked");
  chk_direct_addr: assert property (core_addr != 6'h00 |=> eff_addr == $past(core_addr))
    else $error("direct address altered");
  chk_port5_store: assert property (core_we && core_addr == 6'h05 |=> port5_out == $past(core_wdata))
    else $error("port five latch wrong");
  chk_port7_bit: assert property (core_we && core_addr == 6'h07 |=> port7_out == $past(core_wdata[0]))
    else $error("port seven latch wrong");
  chk_ram_top: assert property (core_re && core_addr == 6'h04 |=> !core_rdata[7])
    else $error("ram select top bit set");
endmodule
bind core_status_bank_select core_regs_assertions u_chk (.*);
`default_nettype wire

/* File: testbench/core_alu_model.sv */
/* Arithmetic unit model: an 8-bit adder that reports its flags.
   Assumes the bench holds the operands for the one cycle of go. */
`timescale 1ns/1ps
`default_nettype none
module core_alu_model (
  input wire logic go,
  input wire logic [7:0] a, b,
  output logic alu_flag_we, alu_zero, alu_half_carry, alu_carry
);
  logic [8:0] sum; // Full sum with carry out.
  assign sum = {1'b0, a} + {1'b0, b};
  assign alu_flag_we = go; // Flags travel with the result.
  assign alu_zero = sum[7:0] == 8'h00;
  assign alu_half_carry = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
  assign alu_carry = sum[8];
endmodule
`default_nettype wire

/* File: testbench/core_status_bank_select_tb.sv */
/* Bench for the core register bank: core port, bus and events.
   Assumes the design package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module core_status_bank_select_tb;
  logic clk_sys = 0, rst_n = 0, core_we = 0, core_re = 0, port7_in = 1, go = 0, irq, ctrl_segment, port7_out;
  logic [5:0] core_addr = 0, eff_addr;
  logic [7:0] core_wdata = 0, port5_in = 8'h96, port6_in = 8'h00, a = 0, b = 0, core_rdata, port5_out, port6_out;
  logic [8:0] m = 0; // Event and program counter strobes.
  logic [9:0] pc_target = 10'h155;
  logic [10:0] pc;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, alu_flag_we;
  logic alu_zero, alu_half_carry, alu_carry, eff_bank;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0, samples_checked = 0, n;
  always #2 clk_sys = ~clk_sys;
  core_status_bank_select u_core_status_bank_select (.ev_sleep(m[0]), .ev_wdt_clear(m[1]), .ev_wdt_timeout(m[2]),
    .ev_wake_pin(m[3]), .ev_wake_other(m[4]), .pc_jump(m[5]), .pc_call(m[6]), .pc_ret(m[7]), .pc_step(m[8]), .*);
  core_alu_model u_core_alu_model (.*);
  task wrap_up; $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly"); else $display("Finished with errors");
    $finish; endtask
  task chk(input logic [33:0] s, e); samples_checked++;
    if (s !== e) begin errors++; $display("BAD value exp %h seen %h", e, s); end endtask
  task hang(input int k); if (k > 60) begin errors++; wrap_up; end endtask
  task aw(input logic [7:0] ad, input logic [31:0] d); @(posedge clk_sys);
    s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    for (n = 0; n < 61 && !s_axi_bvalid; n++) begin @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0; if (s_axi_wready) s_axi_wvalid <= 0; end
    hang(n); chk(s_axi_bresp, 2'b00); s_axi_bready <= 0; endtask
  task ar(input logic [7:0] ad, input logic [33:0] e); @(posedge clk_sys); s_axi_araddr <= ad; s_axi_arvalid <= 1;
    s_axi_rready <= 1; for (n = 0; n < 61 && !s_axi_rvalid; n++) begin @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0; end
    hang(n); chk({s_axi_rresp, s_axi_rdata}, e); s_axi_rready <= 0; endtask
  task cw(input logic [5:0] ad, input logic [7:0] d); @(posedge clk_sys); core_we <= 1; core_addr <= ad;
    core_wdata <= d; @(posedge clk_sys); core_we <= 0; core_addr <= 6'h3f; @(posedge clk_sys); endtask
  task cr(input logic [5:0] ad, input logic [7:0] e); @(posedge clk_sys); core_re <= 1; core_addr <= ad;
    @(posedge clk_sys); core_re <= 0; core_addr <= 6'h3f; @(posedge clk_sys); chk(core_rdata, e); endtask
  task pl(input logic [8:0] v); @(posedge clk_sys); m <= v; @(posedge clk_sys); m <= 0; @(posedge clk_sys); endtask
  task alu(input logic [7:0] x, y, input logic [33:0] e); @(posedge clk_sys); a <= x; b <= y; go <= 1;
    @(posedge clk_sys); go <= 0; ar(8'h0c, e); endtask
  initial begin
    repeat (2) @(posedge clk_sys); rst_n <= 1; repeat (3) @(posedge clk_sys);
    ar(8'h0c, 34'h18);
    aw(8'h28, 32'h1); pl(9'h008); chk(irq, 1); ar(8'h24, 34'h1); @(posedge clk_sys); chk(irq, 0);
    ar(8'h0c, 34'h98); pl(9'h010); ar(8'h0c, 34'h18);
    aw(8'h10, 32'hff); ar(8'h10, 34'h7f);
    cw(4, 8'h25); cw(6'h25, 8'ha5); cw(4, 8'he5); cr(4, 8'h65); cw(0, 8'h5a);
    cw(4, 8'h25); cr(0, 8'ha5); cw(4, 8'h65); cr(0, 8'h5a);
    cw(6'h10, 8'h3c); cw(4, 8'h50); cr(0, 8'h3c);
    cw(5, 8'hc3); chk(port5_out, 8'hc3); ar(8'h14, 34'h96);
    cw(6, 8'h3c); chk(port6_out, 8'h3c); ar(8'h18, 34'h0);
    cw(7, 8'hff); chk(port7_out, 1); ar(8'h1c, 34'h1); ar(8'h3c, 34'h200000000);
    aw(8'h0c, 32'h60); ar(8'h0c, 34'h78); chk(ctrl_segment, 1);
    pl(9'h060); chk(pc, 11'h555); pl(9'h080); chk(pc, 11'h001); ar(8'h0c, 34'h78);
    pl(9'h100); chk(pc, 11'h002);
    alu(8'h88, 8'h78, 34'h7f); alu(8'h01, 8'h02, 34'h78);
    pl(9'h001); ar(8'h0c, 34'h70); chk(irq, 0); pl(9'h004); ar(8'h0c, 34'h60);
    pl(9'h002); ar(8'h0c, 34'h78);
    wrap_up;
  end
endmodule
`default_nettype wire
